// ==== design/vibg_regs.svh ====
// Register offsets, fields and reset values for the VME glue block
`ifndef VIBG_REGS_SVH
`define VIBG_REGS_SVH

`define VIBG_ADR_CFG_A      4'h0
`define VIBG_ADR_CFG_B      4'h1
`define VIBG_ADR_STATUS     4'h2
`define VIBG_ADR_CHANNEL    4'h3

// Port config fields
`define VIBG_CFG_LVL_LSB    0
`define VIBG_CFG_BRL_LSB    3
`define VIBG_CFG_ROR_BIT    5
`define VIBG_CFG_CC_BIT     6
`define VIBG_CFG_DIR_BIT    7
`define VIBG_CFG_RESET      8'h20

// Channel state fields: ch1 and ch3 transition flags, irq enables
`define VIBG_CH_T1_BIT      0
`define VIBG_CH_T3_BIT      1
`define VIBG_CH_E1_BIT      2
`define VIBG_CH_E3_BIT      3
`define VIBG_CH_ERR_BIT     4
`define VIBG_CH_DONE_BIT    5

`endif

// ==== design/vibg_pkg.sv ====
// Types shared by the VME glue block
`default_nettype none
package vibg_pkg;
	typedef enum logic [1:0]
	{
		ARB_IDLE = 2'b00,
		ARB_REQ  = 2'b01,
		ARB_OWN  = 2'b11,
		ARB_PASS = 2'b10
	} vibg_arb_t;

	typedef struct packed
	{
		logic as_n;
		logic lds_n;
		logic uds_n;
		logic iackin_n;
		logic [2:0] addr;
		logic berr_n;
		logic bgin_n;
		logic [3:0] br_n;
	} vibg_vme_in_t;

	typedef struct packed
	{
		logic [3:0] irq_n;
		logic iackout_n;
		logic [3:0] br_n;
		logic bbsy_n;
		logic bgout_n;
	} vibg_vme_out_t;
endpackage
`default_nettype wire

// ==== design/vibg_top.sv ====
// VME interrupter, bus requester and GPIB event glue for two talker/listener ports
// Function
// - DMA irq drives selected VME level low (levels 4-7 only)
// - Ack cycle compares A3-A1 to level
// - Mismatch passes ack until strobe release
// - Match asserts local irq acknowledge
// - Acknowledge held until both strobes release
// - Request held until transition flag cleared
// - Local request raises decoded VME request
// - Grant: busy, drop request, local grant
// - Mirror strobe, drive it after local strobe
// - Unrequested grant passes until grant returns
// - Release-when-finished lets go on acknowledge drop
// - Release-on-request holds until other request
// - Held bus grants local request immediately
// - Talker interrupt high pulls line low
// - Line fall sets flag, raises irq
// - No carry: last byte on done+grant0/2
// - Carry sent: next grant1/3 marks last
// - Last-byte rise arms sync detector
// - Direction 0: valid-line rise means sync
// - Direction 1: valid-line high means sync
// - Bus error sets flags, pulses port line
// - Carry flip-flop toggles after each carry byte
`timescale 1ns/1ps
`default_nettype none
`include "vibg_regs.svh"
module vibg_top
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [3:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire vibg_pkg::vibg_vme_in_t vme_i,
	output vibg_pkg::vibg_vme_out_t     vme_o,
	input  wire logic                   dma_irq_n_i,
	input  wire logic                   dma_bus_req_n_i,
	input  wire logic                   grant_ack_n_i,
	input  wire logic                   dma_as_n_i,
	input  wire logic                   dma_done_n_i,
	input  wire logic [3:0]             ch_grant_n_i,
	input  wire logic [1:0]             tl_int_i,
	input  wire logic [1:0]             dav_n_i,
	output logic                        local_irq_acknowledge_n_o,
	output logic                        local_grant_n_o,
	output logic                        local_addr_strobe_n_o,
	output logic                        vme_as_n_o,
	output logic                        vme_as_oe_o,
	output logic                        periph_line_ch1_n_o,
	output logic                        periph_line_ch3_n_o
);
	import vibg_pkg::*;

	// ----------------------------------------
	// Pin synchronisers (three stages)
	// ----------------------------------------
	localparam int NIN = 17;
	logic [NIN-1:0] pin_raw;
	logic [NIN-1:0] s1;
	logic [NIN-1:0] s2;
	logic [NIN-1:0] s3;
	logic [NIN-1:0] pin;

	assign pin_raw = {vme_i, tl_int_i, dav_n_i};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1 <= {NIN{1'b1}};
			s2 <= {NIN{1'b1}};
			s3 <= {NIN{1'b1}};
			pin <= {NIN{1'b1}};
		end
		else if (ce_i)
		begin
			s1 <= pin_raw;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < NIN; i++)
			begin
				if (s2[i] == s3[i])
					pin[i] <= s3[i];
			end
		end
	end

	vibg_vme_in_t vin;
	logic [1:0]   tl_int;
	logic [1:0]   dav_n;
	assign vin    = pin[NIN-1:4];
	assign tl_int = pin[3:2];
	assign dav_n  = pin[1:0];

	// ----------------------------------------
	// Registers over Wishbone
	// ----------------------------------------
	logic [7:0] cfg_a;
	logic [7:0] cfg_b;
	logic [5:0] chs;
	logic [1:0] armed;
	logic [1:0] line_fall;
	logic       err_set;
	logic       bus_hit;
	logic       wr_hit;

	assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_hit  = bus_hit && wb_we_i && wb_sel_i[0];

	// Priority, request level and release policy are shared; port A's copy rules
	logic [2:0] irq_lvl;
	logic [1:0] br_lvl;
	logic       ror_n;
	assign irq_lvl = cfg_a[`VIBG_CFG_LVL_LSB +: 3];
	assign br_lvl  = cfg_a[`VIBG_CFG_BRL_LSB +: 2];
	assign ror_n   = cfg_a[`VIBG_CFG_ROR_BIT];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= bus_hit;
			case (wb_adr_i)
				`VIBG_ADR_CFG_A:   wb_dat_o <= {24'h0, cfg_a};
				`VIBG_ADR_CFG_B:   wb_dat_o <= {24'h0, cfg_b};
				`VIBG_ADR_STATUS:  wb_dat_o <= {28'h0, armed, local_grant_n_o, vme_o.bbsy_n};
				`VIBG_ADR_CHANNEL: wb_dat_o <= {26'h0, chs};
				default:           wb_dat_o <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_a <= `VIBG_CFG_RESET;
			cfg_b <= `VIBG_CFG_RESET;
		end
		else if (ce_i && wr_hit)
		begin
			if (wb_adr_i == `VIBG_ADR_CFG_A)
				cfg_a <= wb_dat_i[7:0];
			if (wb_adr_i == `VIBG_ADR_CFG_B)
				cfg_b <= wb_dat_i[7:0];
		end
	end

	// Channel flags: write one to clear, a set in the same cycle wins
	logic [5:0] ch_set;
	logic [5:0] ch_clr;
	assign ch_set = {err_set, err_set, 2'b00, line_fall};
	assign ch_clr = (wr_hit && wb_adr_i == `VIBG_ADR_CHANNEL) ?
		{wb_dat_i[5:4], 2'b00, wb_dat_i[1:0]} : 6'h0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			chs <= 6'h0;
		else if (ce_i)
		begin
			chs <= ((chs & ~ch_clr) | ch_set);
			if (wr_hit && wb_adr_i == `VIBG_ADR_CHANNEL)
				chs[3:2] <= wb_dat_i[3:2];
		end
	end

	// ----------------------------------------
	// Interrupter
	// ----------------------------------------
	logic irq_pend;
	logic iack_cyc;
	logic lvl_match;
	assign irq_pend  = (chs[0] && chs[2]) || (chs[1] && chs[3]) || !dma_irq_n_i;
	assign iack_cyc  = !vin.as_n && !vin.lds_n && !vin.iackin_n;
	assign lvl_match = vin.addr == irq_lvl;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			vme_o.irq_n <= 4'hF;
		else if (ce_i)
		begin
			for (int l = 0; l < 4; l++)
				vme_o.irq_n[l] <= !(irq_pend && irq_lvl == 3'(l + 4));
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			vme_o.iackout_n <= 1'b1;
		else if (ce_i)
		begin
			if (vin.as_n)
				vme_o.iackout_n <= 1'b1;
			else if (iack_cyc && !lvl_match)
				vme_o.iackout_n <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			local_irq_acknowledge_n_o <= 1'b1;
		else if (ce_i)
		begin
			if (iack_cyc && lvl_match)
				local_irq_acknowledge_n_o <= 1'b0;
			else if (vin.lds_n && vin.uds_n)
				local_irq_acknowledge_n_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// Bus requester
	// ----------------------------------------
	vibg_arb_t arb;
	logic      other_req;
	assign other_req = !(&vin.br_n);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			arb <= ARB_IDLE;
			vme_o.br_n <= 4'hF;
			vme_o.bbsy_n <= 1'b1;
			vme_o.bgout_n <= 1'b1;
			local_grant_n_o <= 1'b1;
		end
		else if (ce_i)
		begin
			case (arb)
				ARB_IDLE:
				begin
					local_grant_n_o <= 1'b1;
					if (!dma_bus_req_n_i)
					begin
						arb <= ARB_REQ;
						vme_o.br_n <= ~(4'h1 << br_lvl);
					end
					else if (!vin.bgin_n)
					begin
						arb <= ARB_PASS;
						vme_o.bgout_n <= 1'b0;
					end
				end
				ARB_REQ:
					if (!vin.bgin_n)
					begin
						arb <= ARB_OWN;
						vme_o.bbsy_n <= 1'b0;
						vme_o.br_n <= 4'hF;
					end
				ARB_OWN:
				begin
					local_grant_n_o <= dma_bus_req_n_i;
					if (grant_ack_n_i && dma_bus_req_n_i && local_grant_n_o == 1'b0)
						local_grant_n_o <= 1'b1;
					if (grant_ack_n_i && dma_bus_req_n_i && (ror_n || other_req))
					begin
						arb <= ARB_IDLE;
						vme_o.bbsy_n <= 1'b1;
						local_grant_n_o <= 1'b1;
					end
				end
				ARB_PASS:
					if (vin.bgin_n)
					begin
						arb <= ARB_IDLE;
						vme_o.bgout_n <= 1'b1;
					end
				default:
					arb <= ARB_IDLE;
			endcase
		end
	end

	// Strobe mirror; drive VME strobe only while owning and local strobe active
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			local_addr_strobe_n_o <= 1'b1;
			vme_as_n_o <= 1'b1;
			vme_as_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			local_addr_strobe_n_o <= vin.as_n;
			vme_as_oe_o <= (arb == ARB_OWN) && !local_grant_n_o && !dma_as_n_i;
			vme_as_n_o <= dma_as_n_i;
		end
	end

	// ----------------------------------------
	// Per-port last byte, sync detect, events
	// ----------------------------------------
	logic [1:0] carry_done;
	logic [1:0] last_byte;
	logic [1:0] last_q;
	logic [1:0] dav_q;
	logic [1:0] tl_q;
	logic [1:0] sync_ev;
	logic [1:0] line_n;
	logic [3:0] grant_q;
	logic       master;

	assign master = (arb == ARB_OWN) && !local_grant_n_o;
	assign err_set = master && !vin.berr_n && !vme_as_n_o;

	generate
		for (genvar p = 0; p < 2; p++)
		begin : g_port
			logic [7:0] cfg;
			assign cfg = p ? cfg_b : cfg_a;
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					carry_done[p] <= 1'b0;
				else if (ce_i)
				begin
					if (!ch_grant_n_i[2*p+1])
						;
					else if (!grant_q[2*p+1] && cfg[`VIBG_CFG_CC_BIT])
						carry_done[p] <= !carry_done[p];
				end
			end
			assign last_byte[p] = cfg[`VIBG_CFG_CC_BIT] ?
				(carry_done[p] && !ch_grant_n_i[2*p+1]) :
				(!dma_done_n_i && !ch_grant_n_i[2*p]);
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					armed[p] <= 1'b0;
					sync_ev[p] <= 1'b0;
				end
				else if (ce_i)
				begin
					sync_ev[p] <= 1'b0;
					if (last_byte[p] && !last_q[p])
						armed[p] <= 1'b1;
					else if (armed[p] && !dav_n[p] == 1'b0 &&
						(cfg[`VIBG_CFG_DIR_BIT] || dav_q[p] == 1'b0))
					begin
						armed[p] <= 1'b0;
						sync_ev[p] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			last_q <= 2'b0;
			dav_q <= 2'b11;
			tl_q <= 2'b0;
			grant_q <= 4'hF;
			line_n <= 2'b11;
		end
		else if (ce_i)
		begin
			last_q <= last_byte;
			dav_q <= dav_n;
			tl_q <= tl_int;
			grant_q <= ch_grant_n_i;
			// Three-input NOR per port; error goes to the port owning the active grant
			line_n[0] <= !(tl_int[0] || sync_ev[0] ||
				(err_set && !(&ch_grant_n_i[1:0])));
			line_n[1] <= !(tl_int[1] || sync_ev[1] ||
				(err_set && !(&ch_grant_n_i[3:2])));
		end
	end

	logic [1:0] line_q;
	assign line_fall = {!line_n[1] && line_q[1],
		!line_n[0] && line_q[0]};
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			line_q <= 2'b11;
		else if (ce_i)
			line_q <= line_n;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			periph_line_ch1_n_o <= 1'b1;
			periph_line_ch3_n_o <= 1'b1;
		end
		else if (ce_i)
		begin
			periph_line_ch1_n_o <= line_n[0];
			periph_line_ch3_n_o <= line_n[1];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_iack_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !local_irq_acknowledge_n_o && !(vin.lds_n && vin.uds_n)
		|=> !local_irq_acknowledge_n_o)
		else $error("irq acknowledge dropped early");
	chk_iackout_as: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && vin.as_n |=> vme_o.iackout_n)
		else $error("daisy ack held past strobe");
	chk_bbsy_grant: assert property (@(posedge clk_i) disable iff (rst_i)
		!local_grant_n_o && arb == ARB_OWN |-> !vme_o.bbsy_n && &vme_o.br_n)
		else $error("grant without busy");
	chk_pass_grant: assert property (@(posedge clk_i) disable iff (rst_i)
		arb == ARB_PASS |-> !vme_o.bgout_n && &vme_o.br_n)
		else $error("grant not passed");
	chk_sync_disarm: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && sync_ev[0] |-> !armed[0])
		else $error("detector still armed");
	chk_line_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && line_fall[0] |=> chs[0])
		else $error("flag not set");
	chk_tl_line: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && tl_int[0] |=> !line_n[0])
		else $error("talker irq not on line");
	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && chs[0] && chs[2] && irq_lvl == 3'h4 |=> !vme_o.irq_n[0])
		else $error("irq level not driven");
endmodule
`default_nettype wire

// ==== dv/vibg_vme_far.sv ====
// VME far side model: interrupt handler and bus arbiter
`timescale 1ns/1ps
`default_nettype none
module vibg_vme_far
(
	input  wire logic                    clk_i,
	input  wire vibg_pkg::vibg_vme_out_t vme_o_i,
	input  wire logic                    iack_go_i,
	input  wire logic [2:0]              iack_lvl_i,
	input  wire logic                    stray_grant_i,
	output vibg_pkg::vibg_vme_in_t       vme_i_o
);
	import vibg_pkg::*;
	logic gnt;
	// ------------------------------
	// Arbiter
	// ------------------------------
	always_ff @(posedge clk_i)
	begin
		gnt <= stray_grant_i || (vme_o_i.br_n != 4'hF);
	end
	// ------------------------------
	// Handler drive
	// ------------------------------
	// Strobes pulled up when released; address shows the inverse
	always_comb
	begin
		vme_i_o.as_n     = !iack_go_i;
		vme_i_o.lds_n    = !iack_go_i;
		vme_i_o.uds_n    = !iack_go_i;
		vme_i_o.iackin_n = !iack_go_i;
		vme_i_o.addr     = iack_go_i ? iack_lvl_i : ~iack_lvl_i;
		vme_i_o.berr_n   = 1'b1;
		vme_i_o.bgin_n   = !gnt;
		vme_i_o.br_n     = 4'hF;
	end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the VME glue block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import vibg_pkg::*;
	logic           clk_i;
	logic           rst_i;
	logic           ce;
	logic           wb_cyc, wb_stb, wb_we;
	logic [3:0]     wb_adr;
	logic [31:0]    wb_wdat, wb_dat_o, rd;
	logic           wb_ack_o;
	vibg_vme_in_t   vme_i;
	vibg_vme_out_t  vme_o;
	logic           irq_n, breq_n, gack_n, go, stray;
	logic [2:0]     lvl;
	logic [1:0]     tl_int;
	logic           liack_n, lgnt_n, las_n, as_n, as_oe, pl1_n, pl3_n;
	int             err_count, cmp_count, cyc, n;
	logic [3:0]     exp_irq [8] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hE, 4'hD, 4'hB, 4'h7};

	vibg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vme_i(vme_i),
		.vme_o(vme_o), .dma_irq_n_i(irq_n), .dma_bus_req_n_i(breq_n),
		.grant_ack_n_i(gack_n), .dma_as_n_i(1'b1), .dma_done_n_i(1'b1),
		.ch_grant_n_i(4'hF), .tl_int_i(tl_int), .dav_n_i(2'b11),
		.local_irq_acknowledge_n_o(liack_n), .local_grant_n_o(lgnt_n),
		.local_addr_strobe_n_o(las_n), .vme_as_n_o(as_n), .vme_as_oe_o(as_oe),
		.periph_line_ch1_n_o(pl1_n), .periph_line_ch3_n_o(pl3_n));

	vibg_vme_far u_far (.clk_i(clk_i), .vme_o_i(vme_o), .iack_go_i(go),
		.iack_lvl_i(lvl), .stray_grant_i(stray), .vme_i_o(vme_i));

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
		int k;
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= we;
		wb_adr  <= adr;
		wb_wdat <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (wb_ack_o !== 1'b1 && k < 50);
		if (k >= 50)
			err_count++;
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// Covers synchroniser depth plus output registers
	task automatic settle;
		repeat (12) @(posedge clk_i);
	endtask

	task automatic end_sim;
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim();
		end
	end

	initial
	begin
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
		{irq_n, breq_n, gack_n, go, stray, lvl, tl_int} = {3'b111, 2'b00, 3'h0, 2'b00};
		ce = 1'b1;
		{err_count, cmp_count, cyc} = '0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// ------------------------------
		// Reset values and registers
		// ------------------------------
		chk(vme_o, 11'h7FF);
		chk({liack_n, lgnt_n, las_n, pl1_n, pl3_n, as_oe}, 6'h3E);
		wb(1'b0, 4'h0, 0); chk(rd, 32'h20);
		wb(1'b0, 4'h1, 0); chk(rd, 32'h20);
		wb(1'b1, 4'h9, 32'hFF);
		wb(1'b0, 4'h9, 0); chk(rd, 32'h0);
		// ------------------------------
		// Level table
		// ------------------------------
		for (int i = 0; i < 8; i++)
		begin
			wb(1'b1, 4'h0, 32'h20 | i);
			irq_n <= 1'b0;
			settle();
			chk(vme_o.irq_n, exp_irq[i]);
			irq_n <= 1'b1;
			settle();
		end
		// ------------------------------
		// Acknowledge cycles at level 5
		// ------------------------------
		wb(1'b1, 4'h0, 32'h25);
		lvl <= 3'h6;
		go  <= 1'b1;
		settle();
		chk({vme_o.iackout_n, liack_n}, 2'b01);
		go <= 1'b0;
		settle();
		chk(vme_o.iackout_n, 1'b1);
		lvl <= 3'h5;
		go  <= 1'b1;
		settle();
		chk({vme_o.iackout_n, liack_n}, 2'b10);
		go <= 1'b0;
		settle();
		chk(liack_n, 1'b1);
		// ------------------------------
		// Arbitration, release when finished
		// ------------------------------
		wb(1'b1, 4'h0, 32'h30);
		breq_n <= 1'b0;
		n = 0;
		while (vme_o.br_n !== 4'hB && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(vme_o.br_n, 4'hB);
		settle();
		chk({vme_o.bbsy_n, vme_o.br_n, lgnt_n}, 6'h1E);
		gack_n <= 1'b0;
		breq_n <= 1'b1;
		settle();
		gack_n <= 1'b1;
		settle();
		chk(vme_o.bbsy_n, 1'b1);
		// ------------------------------
		// Unrequested grant passes on
		// ------------------------------
		stray <= 1'b1;
		settle();
		chk(vme_o.bgout_n, 1'b0);
		stray <= 1'b0;
		settle();
		chk(vme_o.bgout_n, 1'b1);
		// ------------------------------
		// Release on request keeps the bus
		// ------------------------------
		wb(1'b1, 4'h0, 32'h10);
		breq_n <= 1'b0;
		settle();
		gack_n <= 1'b0;
		breq_n <= 1'b1;
		settle();
		gack_n <= 1'b1;
		settle();
		chk(vme_o.bbsy_n, 1'b0);
		breq_n <= 1'b0;
		settle();
		chk({vme_o.br_n, lgnt_n}, 5'h1E);
		breq_n <= 1'b1;
		// ------------------------------
		// Talker interrupt to port line
		// ------------------------------
		tl_int <= 2'b01;
		settle();
		chk({pl1_n, pl3_n}, 2'b01);
		wb(1'b0, 4'h3, 0);
		chk(rd[0], 1'b1);
		// Clock enable low must freeze the port B path
		ce <= 1'b0;
		tl_int <= 2'b11;
		settle();
		chk(pl3_n, 1'b1);
		ce <= 1'b1;
		settle();
		chk(pl3_n, 1'b0);
		wb(1'b0, 4'h3, 0);
		chk(rd[1], 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
